// >>> logic/dac_mode_pkg.sv
package dac_mode_pkg;

  // ==========================================================================
  // Control word layout
  // ==========================================================================
  localparam int WORD_BITS = 16;
  localparam int START_BIT = 15;
  localparam int INDEX_MSB = 14;
  localparam int INDEX_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int LATCH_SYNC_STAGES = 3;

  // ==========================================================================
  // Register indices
  // ==========================================================================
  localparam logic [6:0] IDX_LEFT_ATTEN = 7'h10;
  localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
  localparam logic [6:0] IDX_MUTE_OVER = 7'h12;
  localparam logic [6:0] IDX_DAC_DEEMPH = 7'h13;
  localparam logic [6:0] IDX_FORMAT = 7'h14;
  localparam logic [6:0] IDX_TEST = 7'h15;
  localparam logic [6:0] IDX_ZERO_FLAG = 7'h16;

  // ==========================================================================
  // Reset values and writable bit masks
  // ==========================================================================
  localparam logic [7:0] ATTEN_RESET = 8'hFF;
  localparam logic [7:0] MUTE_OVER_RESET = 8'h00;
  localparam logic [7:0] DAC_DEEMPH_RESET = 8'h00;
  localparam logic [7:0] FORMAT_RESET = 8'h05;
  localparam logic [7:0] ZERO_FLAG_RESET = 8'h00;
  localparam logic [7:0] MUTE_OVER_MASK = 8'h43;
  localparam logic [7:0] DAC_DEEMPH_MASK = 8'h73;
  localparam logic [7:0] FORMAT_MASK = 8'h27;
  localparam logic [7:0] ZERO_FLAG_MASK = 8'h07;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int MUTE_L_BIT = 0;
  localparam int MUTE_R_BIT = 1;
  localparam int OVER_BIT = 6;
  localparam int DAC_L_BIT = 0;
  localparam int DAC_R_BIT = 1;
  localparam int DEEMPH_EN_BIT = 4;
  localparam int DEEMPH_RATE_LSB = 5;
  localparam int DEEMPH_RATE_MSB = 6;
  localparam int FMT_LSB = 0;
  localparam int FMT_MSB = 2;
  localparam int ROLLOFF_BIT = 5;
  localparam int PHASE_BIT = 0;
  localparam int ZPOL_BIT = 1;
  localparam int ZMERGE_BIT = 2;

  // ==========================================================================
  // Attenuation and format codes
  // ==========================================================================
  localparam logic [7:0] ATTEN_MUTE = 8'h80;
  localparam logic [8:0] ATTEN_UNITY = 9'h0FF;
  localparam int STEP_SAMPLES = 8;
  localparam logic [1:0] DEEMPH_RATE_RSVD = 2'h3;
  localparam logic [2:0] FMT_RJ24 = 3'h0;
  localparam logic [2:0] FMT_RJ20 = 3'h1;
  localparam logic [2:0] FMT_RJ18 = 3'h2;
  localparam logic [2:0] FMT_RJ16 = 3'h3;
  localparam logic [2:0] FMT_I2S = 3'h4;
  localparam logic [2:0] FMT_LJ = 3'h5;

  // Word length of a right-justified format, zero for any other code.
  function automatic logic [4:0] fmt_rj_width(input logic [2:0] fmt);
    case (fmt)
      FMT_RJ24: fmt_rj_width = 5'h18;
      FMT_RJ20: fmt_rj_width = 5'h14;
      FMT_RJ18: fmt_rj_width = 5'h12;
      FMT_RJ16: fmt_rj_width = 5'h10;
      default: fmt_rj_width = 5'h00;
    endcase
  endfunction : fmt_rj_width

  // Gain in half-decibel units; meaningful above the mute code only.
  function automatic logic signed [8:0] gain_half_db(input logic [7:0] lvl);
    gain_half_db = $signed({1'b0, lvl}) - $signed(ATTEN_UNITY);
  endfunction : gain_half_db

  function automatic logic index_mapped(input logic [6:0] idx);
    index_mapped = (idx >= IDX_LEFT_ATTEN) && (idx <= IDX_ZERO_FLAG);
  endfunction : index_mapped

endpackage : dac_mode_pkg

// >>> logic/control_shift_rx.sv
`timescale 1ns/1ps
module control_shift_rx
  import dac_mode_pkg::*;
#(
  parameter int WIDTH = WORD_BITS
) (
  // Serial control pins.
  input wire logic control_bit_clock,
  input wire logic control_latch,
  input wire logic control_serial_in,
  // Clear from the system domain.
  input wire logic link_clear,
  // Captured frame.
  output logic [WIDTH-1:0] word,
  output logic word_complete
);

  // ==========================================================================
  // Bit counter, held clear while the latch is high
  // ==========================================================================
  localparam logic [4:0] COUNT_FULL = 5'(WIDTH);
  localparam logic [4:0] COUNT_LAST = 5'(WIDTH - 1);
  logic [4:0] bit_count;
  wire count_open = bit_count != COUNT_FULL;

  always_ff @(posedge control_bit_clock or posedge control_latch) begin
    if (control_latch) begin
      bit_count <= 5'h00;
    end else if (count_open) begin
      bit_count <= bit_count + 5'h01;
    end
  end

  // ==========================================================================
  // Shift register and frame length flag
  // ==========================================================================
  // The flag survives the latch rising so the system side can still see it.
  always_ff @(posedge control_bit_clock or posedge link_clear) begin
    if (link_clear) begin
      word <= '0;
      word_complete <= 1'b0;
    end else if (!control_latch) begin
      word <= {word[WIDTH-2:0], control_serial_in};
      word_complete <= bit_count == COUNT_LAST;
    end
  end

  AST_SHIFT_IN: assert property (
    @(posedge control_bit_clock) disable iff (link_clear)
    !control_latch |=> word[0] == $past(control_serial_in)
  ) else $error("control bit not shifted in");

  AST_SIXTEEN_BITS: assert property (
    @(posedge control_bit_clock) disable iff (link_clear)
    !control_latch && bit_count != COUNT_LAST |=> !word_complete
  ) else $error("frame marked complete at wrong bit count");

endmodule : control_shift_rx

// >>> logic/atten_ramp.sv
`timescale 1ns/1ps
module atten_ramp
  import dac_mode_pkg::*;
#(
  parameter int STEP_TICKS = STEP_SAMPLES
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Settings and sample timing.
  input wire logic [7:0] target,
  input wire logic soft_mute,
  input wire logic sample_tick,
  // Applied level.
  output logic [7:0] level,
  output logic muted,
  output logic ramping
);

  // ==========================================================================
  // Step timing, one step every STEP_TICKS sample periods
  // ==========================================================================
  localparam logic [2:0] TICK_LAST = 3'(STEP_TICKS - 1);
  logic [2:0] tick_count;
  wire step = sample_tick && (tick_count == TICK_LAST);
  // The counter restarts after each step; its three bits fit step spacings of up to eight ticks.
  wire [2:0] next_tick_count = step ? 3'h0 :
                               sample_tick ? tick_count + 3'h1 : tick_count;
  wire target_mutes = target <= ATTEN_MUTE;
  wire [7:0] goal = (soft_mute || target_mutes) ? ATTEN_MUTE : target;
  wire [7:0] next_level = !step ? level :
                          (level < goal) ? level + 8'h01 :
                          (level > goal) ? level - 8'h01 : level;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tick_count <= 3'h0;
      level <= ATTEN_RESET;
    end else begin
      tick_count <= next_tick_count;
      level <= next_level;
    end
  end

  assign muted = level <= ATTEN_MUTE;
  assign ramping = level != goal;

  AST_STEADY_BETWEEN_STEPS: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !step |=> $stable(level)
  ) else $error("level moved outside a step");

  AST_STEP_UP: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    step && level < goal |=> level == $past(level) + 8'h01
  ) else $error("level did not rise by one step");

  AST_SOFT_MUTE_DOWN: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    step && soft_mute && level > ATTEN_MUTE |=> level == $past(level) - 8'h01
  ) else $error("soft mute did not lower level");

  AST_MUTE_FLOOR: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    target_mutes && level == ATTEN_MUTE |=> level == ATTEN_MUTE && muted
  ) else $error("mute code left mute floor");

endmodule : atten_ramp

// >>> logic/dac_mode_control.sv
`timescale 1ns/1ps
// Summary of operation
// - Word: zero, 7-bit index, 8 data bits
// - Latch low, sixteen clocks, rising latch commits
// - Index taken from word bits 14 to 8
// - Index 16 left, 17 right attenuation
// - Gain is half dB times code minus 255
// - Codes 0 to 128 mute the channel
// - Level ramps one step per eight samples
// - Attenuation registers reset to all ones
// - Soft mute ramps down, release ramps back
// - Index 18 mute and oversampling, reset off
// - Index 19 converter disables reset clear
// - Index 19 de-emphasis enable and rate
// - Index 20 format resets left-justified
// - Format codes decode; 110, 111 reserved
// - Index 20 rolloff resets to sharp
// - Index 22 zero flag and phase bits
module dac_mode_control
  import dac_mode_pkg::*;
(
  // System clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Serial control port.
  input wire logic control_bit_clock,
  input wire logic control_latch,
  input wire logic control_serial_in,
  // Sample period strobe, one cycle per sample.
  input wire logic sample_tick,
  // Programmed and applied attenuation.
  output logic [7:0] left_atten_level,
  output logic [7:0] right_atten_level,
  output logic [7:0] left_applied_level,
  output logic [7:0] right_applied_level,
  output logic signed [8:0] left_gain_half_db,
  output logic signed [8:0] right_gain_half_db,
  output logic left_muted,
  output logic right_muted,
  output logic left_ramping,
  output logic right_ramping,
  // Mute and oversampling.
  output logic left_soft_mute,
  output logic right_soft_mute,
  output logic oversample_128x,
  // Converter and de-emphasis.
  output logic left_converter_disable,
  output logic right_converter_disable,
  output logic deemph_enable,
  output logic [1:0] deemph_rate_sel,
  output logic deemph_rate_reserved,
  // Format and filter.
  output logic [2:0] audio_format_sel,
  output logic [4:0] fmt_rj_bits,
  output logic fmt_right_justified,
  output logic fmt_i2s,
  output logic fmt_left_justified,
  output logic fmt_reserved,
  output logic rolloff_sel,
  // Zero flag and phase.
  output logic zero_flag_merge,
  output logic zero_flag_polarity,
  output logic output_phase_invert,
  // Write monitor.
  output logic [6:0] register_index,
  output logic write_strobe
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0] left_attenuation;
  logic [7:0] right_attenuation;
  logic [7:0] mute_oversampling_control;
  logic [7:0] dac_deemphasis_control;
  logic [7:0] format_filter_control;
  logic [7:0] output_zero_flag_control;

  // ==========================================================================
  // Link domain receiver
  // ==========================================================================
  logic link_clear;
  logic [WORD_BITS-1:0] rx_word;
  logic rx_complete;

  // Held high during system reset so the link side starts empty.
  always_ff @(posedge sys_clk) begin
    link_clear <= !resetn;
  end

  control_shift_rx #(
    .WIDTH(WORD_BITS)
  ) u_rx (
    .control_bit_clock(control_bit_clock),
    .control_latch(control_latch),
    .control_serial_in(control_serial_in),
    .link_clear(link_clear),
    .word(rx_word),
    .word_complete(rx_complete)
  );

  // ==========================================================================
  // Latch synchroniser and commit detection
  // ==========================================================================
  // The frame word is not resynchronised: the bit clock is quiet once the
  // latch is high, so the word is stable by the time the edge is seen here.
  logic [LATCH_SYNC_STAGES-1:0] latch_sync;
  logic latch_level;
  wire latch_agree = latch_sync[1] == latch_sync[2];
  wire latch_rise = latch_agree && latch_sync[2] && !latch_level;
  wire next_latch_level = latch_agree ? latch_sync[2] : latch_level;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      latch_sync <= '1;
      latch_level <= 1'b1;
    end else begin
      latch_sync <= {latch_sync[1:0], control_latch};
      latch_level <= next_latch_level;
    end
  end

  // ==========================================================================
  // Word decode
  // ==========================================================================
  wire [6:0] word_index = rx_word[INDEX_MSB:INDEX_LSB];
  wire [7:0] word_data = rx_word[DATA_MSB:0];
  wire word_ok = rx_complete && !rx_word[START_BIT];
  wire commit = latch_rise && word_ok && index_mapped(word_index);
  wire wr_left = commit && (word_index == IDX_LEFT_ATTEN);
  wire wr_right = commit && (word_index == IDX_RIGHT_ATTEN);
  wire wr_mute = commit && (word_index == IDX_MUTE_OVER);
  wire wr_dac = commit && (word_index == IDX_DAC_DEEMPH);
  wire wr_format = commit && (word_index == IDX_FORMAT);
  wire wr_zero = commit && (word_index == IDX_ZERO_FLAG);

  // ==========================================================================
  // Register writes
  // ==========================================================================
  // Test register writes are accepted but change nothing; reserved bits are
  // dropped so they always read back as zero on the outputs.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      left_attenuation <= ATTEN_RESET;
      right_attenuation <= ATTEN_RESET;
    end else begin
      left_attenuation <= wr_left ? word_data : left_attenuation;
      right_attenuation <= wr_right ? word_data : right_attenuation;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mute_oversampling_control <= MUTE_OVER_RESET;
      dac_deemphasis_control <= DAC_DEEMPH_RESET;
      format_filter_control <= FORMAT_RESET;
      output_zero_flag_control <= ZERO_FLAG_RESET;
    end else begin
      if (wr_mute) begin
        mute_oversampling_control <= word_data & MUTE_OVER_MASK;
      end
      if (wr_dac) begin
        dac_deemphasis_control <= word_data & DAC_DEEMPH_MASK;
      end
      if (wr_format) begin
        format_filter_control <= word_data & FORMAT_MASK;
      end
      if (wr_zero) begin
        output_zero_flag_control <= word_data & ZERO_FLAG_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      register_index <= 7'h00;
      write_strobe <= 1'b0;
    end else begin
      register_index <= commit ? word_index : register_index;
      write_strobe <= commit;
    end
  end

  // ==========================================================================
  // Attenuation ramps
  // ==========================================================================
  atten_ramp #(
    .STEP_TICKS(STEP_SAMPLES)
  ) u_left_ramp (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .target(left_attenuation),
    .soft_mute(mute_oversampling_control[MUTE_L_BIT]),
    .sample_tick(sample_tick),
    .level(left_applied_level),
    .muted(left_muted),
    .ramping(left_ramping)
  );

  atten_ramp #(
    .STEP_TICKS(STEP_SAMPLES)
  ) u_right_ramp (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .target(right_attenuation),
    .soft_mute(mute_oversampling_control[MUTE_R_BIT]),
    .sample_tick(sample_tick),
    .level(right_applied_level),
    .muted(right_muted),
    .ramping(right_ramping)
  );

  // ==========================================================================
  // Field outputs
  // ==========================================================================
  assign left_atten_level = left_attenuation;
  assign right_atten_level = right_attenuation;
  assign left_gain_half_db = gain_half_db(left_applied_level);
  assign right_gain_half_db = gain_half_db(right_applied_level);
  assign left_soft_mute = mute_oversampling_control[MUTE_L_BIT];
  assign right_soft_mute = mute_oversampling_control[MUTE_R_BIT];
  assign oversample_128x = mute_oversampling_control[OVER_BIT];
  assign left_converter_disable = dac_deemphasis_control[DAC_L_BIT];
  assign right_converter_disable = dac_deemphasis_control[DAC_R_BIT];
  assign deemph_enable = dac_deemphasis_control[DEEMPH_EN_BIT];
  assign deemph_rate_sel =
    dac_deemphasis_control[DEEMPH_RATE_MSB:DEEMPH_RATE_LSB];
  assign deemph_rate_reserved = deemph_rate_sel == DEEMPH_RATE_RSVD;
  assign audio_format_sel = format_filter_control[FMT_MSB:FMT_LSB];
  assign fmt_rj_bits = fmt_rj_width(audio_format_sel);
  assign fmt_right_justified = fmt_rj_bits != 5'h00;
  assign fmt_i2s = audio_format_sel == FMT_I2S;
  assign fmt_left_justified = audio_format_sel == FMT_LJ;
  assign fmt_reserved = audio_format_sel > FMT_LJ;
  assign rolloff_sel = format_filter_control[ROLLOFF_BIT];
  assign zero_flag_merge = output_zero_flag_control[ZMERGE_BIT];
  assign zero_flag_polarity = output_zero_flag_control[ZPOL_BIT];
  assign output_phase_invert = output_zero_flag_control[PHASE_BIT];

  // ==========================================================================
  // Checks
  // ==========================================================================
  AST_INDEX_DECODE: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    commit |=> write_strobe && register_index == $past(rx_word[14:8])
  ) else $error("committed index not taken from bits 14 to 8");

  AST_LEFT_WRITE: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    wr_left |=> left_atten_level == $past(word_data) &&
      $stable(right_atten_level)
  ) else $error("left attenuation write wrong");

  AST_RIGHT_WRITE: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    wr_right |=> right_atten_level == $past(word_data) &&
      $stable(left_atten_level)
  ) else $error("right attenuation write wrong");

  AST_IGNORE_UNMAPPED: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    latch_rise && !index_mapped(word_index) |=>
      $stable(left_attenuation) && $stable(right_attenuation) &&
      $stable(mute_oversampling_control) &&
      $stable(dac_deemphasis_control) &&
      $stable(format_filter_control) &&
      $stable(output_zero_flag_control) && !write_strobe
  ) else $error("unmapped index changed settings");

  AST_COMMIT_ON_LATCH: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    write_strobe |-> $past(latch_sync[2]) && !$past(latch_level, 2)
  ) else $error("write committed without latch rising");

  AST_RESET_ATTEN: assert property (
    @(posedge sys_clk)
    !resetn |=> left_atten_level == 8'hFF && right_atten_level == 8'hFF
  ) else $error("attenuation reset value wrong");

  AST_RESET_MUTE_OVER: assert property (
    @(posedge sys_clk)
    !resetn |=> !left_soft_mute && !right_soft_mute && !oversample_128x
  ) else $error("mute or oversampling reset wrong");

  AST_RESET_DAC: assert property (
    @(posedge sys_clk)
    !resetn |=> !left_converter_disable && !right_converter_disable
  ) else $error("converter disable reset wrong");

  AST_RESET_DEEMPH: assert property (
    @(posedge sys_clk)
    !resetn |=> !deemph_enable && deemph_rate_sel == 2'h0
  ) else $error("de-emphasis reset wrong");

  AST_RESET_FORMAT: assert property (
    @(posedge sys_clk)
    !resetn |=> audio_format_sel == 3'h5 && fmt_left_justified
  ) else $error("format reset wrong");

  AST_RESET_ROLLOFF: assert property (
    @(posedge sys_clk)
    !resetn |=> !rolloff_sel
  ) else $error("rolloff reset wrong");

  AST_RESET_ZERO: assert property (
    @(posedge sys_clk)
    !resetn |=> !zero_flag_merge && !zero_flag_polarity &&
      !output_phase_invert
  ) else $error("zero flag or phase reset wrong");

  AST_FORMAT_DECODE: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (audio_format_sel == 3'h3 |-> fmt_rj_bits == 5'h10) and
    (audio_format_sel == 3'h0 |-> fmt_rj_bits == 5'h18) and
    (audio_format_sel[2:1] == 2'h3 |-> fmt_reserved && !fmt_i2s)
  ) else $error("format decode wrong");

  AST_GAIN_FORMULA: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    left_applied_level == 8'h81 |-> left_gain_half_db == -9'sd126
  ) else $error("gain formula wrong at lowest step");

endmodule : dac_mode_control

// >>> sim/host_model.sv
`timescale 1ns/1ps
// ============================================================
// Host controller on the serial control port.
module host_model (
  // Serial control pins.
  output logic control_bit_clock,
  output logic control_latch,
  output logic control_serial_in
);
  initial begin
    control_bit_clock = 1'b0;
    control_latch = 1'b1;
    control_serial_in = 1'b0;
  end

  // Sends the top n bits MSB first; callers keep reserved bits zero.
  task automatic send(input logic [15:0] w, input int n);
    #300;
    control_latch = 1'b0;
    #20;
    for (int i = 15; i > 15 - n; i--) begin
      control_serial_in = w[i];
      #3 control_bit_clock = 1'b1;
      #3 control_bit_clock = 1'b0;
    end
    #20 control_latch = 1'b1;
    control_serial_in = ~control_serial_in;
  endtask : send
endmodule : host_model

// >>> sim/tb_dac_mode_control.sv
`timescale 1ns/1ps
// ============================================================
// Stimulus and checks for the mode register bank.
module tb_dac_mode_control;
  import dac_mode_pkg::*;
  logic sys_clk, resetn, sample_tick;
  logic control_bit_clock, control_latch, control_serial_in;
  logic [7:0] left_atten_level, right_atten_level;
  logic [7:0] left_applied_level, right_applied_level;
  logic signed [8:0] left_gain_half_db, right_gain_half_db;
  logic left_muted, right_muted, left_ramping, right_ramping;
  logic left_soft_mute, right_soft_mute, oversample_128x;
  logic left_converter_disable, right_converter_disable, deemph_enable;
  logic [1:0] deemph_rate_sel;
  logic deemph_rate_reserved, fmt_right_justified, fmt_i2s;
  logic fmt_left_justified, fmt_reserved, rolloff_sel, write_strobe;
  logic zero_flag_merge, zero_flag_polarity, output_phase_invert;
  logic [2:0] audio_format_sel;
  logic [4:0] fmt_rj_bits;
  logic [6:0] register_index;
  logic [4:0] rjw [8] = '{5'h18, 5'h14, 5'h12, 5'h10, 0, 0, 0, 0};
  int error_cnt = 0;
  int checked = 0;

  host_model host (.control_bit_clock, .control_latch,
    .control_serial_in);
  dac_mode_control DUT (.sys_clk, .resetn, .control_bit_clock,
    .control_latch, .control_serial_in, .sample_tick, .left_atten_level,
    .right_atten_level, .left_applied_level, .right_applied_level,
    .left_gain_half_db, .right_gain_half_db, .left_muted, .right_muted,
    .left_ramping, .right_ramping, .left_soft_mute, .right_soft_mute,
    .oversample_128x, .left_converter_disable, .right_converter_disable,
    .deemph_enable, .deemph_rate_sel, .deemph_rate_reserved,
    .audio_format_sel, .fmt_rj_bits, .fmt_right_justified, .fmt_i2s,
    .fmt_left_justified, .fmt_reserved, .rolloff_sel, .zero_flag_merge,
    .zero_flag_polarity, .output_phase_invert, .register_index,
    .write_strobe);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [8:0] e,
    input logic [8:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [15:0] w, input int n, input logic s);
    logic seen;
    seen = 1'b0;
    host.send(w, n);
    repeat (10) begin
      @(negedge sys_clk);
      if (write_strobe === 1'b1) begin
        seen = 1'b1;
      end
    end
    chk("write_strobe", s, seen);
    @(negedge sys_clk);
  endtask : wr

  task automatic tk(input int n);
    repeat (n) begin
      @(negedge sys_clk) sample_tick = 1'b1;
      @(negedge sys_clk) sample_tick = 1'b0;
    end
  endtask : tk

  task automatic print_verdict;
    $display("Checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #1000000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    resetn = 1'b0;
    sample_tick = 1'b0;
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    chk("atten", 9'h1FF, {left_atten_level, right_atten_level[0]});
    chk("mute_over", 0, {left_soft_mute, right_soft_mute, oversample_128x});
    chk("dac", 0, {left_converter_disable, right_converter_disable});
    chk("deemph", 0, {deemph_enable, deemph_rate_sel});
    chk("audio_format_sel", 5, audio_format_sel);
    chk("rolloff_sel", 0, rolloff_sel);
    chk("zero", 0, {zero_flag_merge, zero_flag_polarity, output_phase_invert});
    wr(16'h1373, 16, 1);
    chk("register_index", 7'h13, register_index);
    chk("reg19", 9'h03F, {left_converter_disable, right_converter_disable,
      deemph_enable, deemph_rate_sel, deemph_rate_reserved});
    wr(16'h1607, 16, 1);
    chk("zero", 7, {zero_flag_merge, zero_flag_polarity, output_phase_invert});
    for (int c = 0; c < 8; c++) begin
      wr({8'h14, 3'b001, 2'b00, c[2:0]}, 16, 1);
      chk("audio_format_sel", c[2:0], audio_format_sel);
      chk("fmt", {rjw[c], c < 4, c == 4, c == 5, c > 5}, {fmt_rj_bits,
        fmt_right_justified, fmt_i2s, fmt_left_justified, fmt_reserved});
      chk("rolloff_sel", 1, rolloff_sel);
    end
    wr(16'h9400, 16, 0);
    wr(16'h1700, 16, 0);
    wr(16'h0F00, 16, 0);
    wr(16'h1400, 15, 0);
    chk("register_index", 7'h14, register_index);
    wr(16'h1500, 16, 1);
    chk("register_index", 7'h15, register_index);
    chk("audio_format_sel", 7, audio_format_sel);
    wr(16'h10FD, 16, 1);
    chk("left_atten_level", 9'h0FD, left_atten_level);
    tk(8);
    chk("left_applied", 9'h0FE, left_applied_level);
    chk("left_ramping", 1, left_ramping);
    tk(8);
    chk("left_applied", 9'h0FD, left_applied_level);
    chk("left_gain", 9'h1FE, left_gain_half_db);
    chk("right_applied", 9'h0FF, right_applied_level);
    chk("right_gain", 0, right_gain_half_db);
    tk(8);
    chk("left_hold", 9'h1FA, {left_applied_level, left_ramping});
    wr(16'h1100, 16, 1);
    wr(16'h1201, 16, 1);
    chk("left_soft_mute", 1, left_soft_mute);
    chk("right_soft_mute", 0, right_soft_mute);
    tk(992);
    chk("left", 9'h102, {left_applied_level, left_muted});
    chk("right_applied", 9'h083, right_applied_level);
    tk(8);
    chk("left", 9'h101, {left_applied_level, left_muted});
    tk(16);
    chk("right", 9'h101, {right_applied_level, right_muted});
    chk("right_ramping", 0, right_ramping);
    wr(16'h1242, 16, 1);
    chk("oversample_128x", 1, oversample_128x);
    chk("right_soft_mute", 1, right_soft_mute);
    tk(8);
    chk("left", 9'h102, {left_applied_level, left_muted});
    resetn = 1'b0;
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    chk("atten_rst", 9'h1FF, {left_atten_level, &right_atten_level});
    chk("appl_rst", 9'h1FF, {left_applied_level, &right_applied_level});
    chk("over_rst", 0, {right_soft_mute, oversample_128x});
    chk("audio_format_sel", 5, audio_format_sel);
    wr(16'h10F0, 16, 1);
    chk("left_atten_level", 9'h0F0, left_atten_level);
    print_verdict();
  end
endmodule : tb_dac_mode_control
